// file: include/clock_gating_pkg.sv
package clock_gating_pkg;

  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned SEL_W       = DATA_W / 8;
  localparam int unsigned NUM_GATE_REGS = 6;
  localparam int unsigned NUM_GATES   = 33;

  // byte addresses
  localparam logic [ADDR_W-1:0] SYS_CFG_CTRL_ADDR = 16'hf200;
  localparam logic [ADDR_W-1:0] GATE_REG_BASE     = 16'hf240;
  localparam logic [ADDR_W-1:0] GATE_STATUS_ADDR  = 16'hf258;
  localparam logic [ADDR_W-1:0] WORD_STRIDE       = 16'h0004;

  // system config control layout
  localparam logic [DATA_W-1:0] SYS_CFG_RESET      = 32'h0000000b;
  localparam logic [DATA_W-1:0] SYS_CFG_WR_MASK    = 32'h0000300d;
  localparam int unsigned       GATE_LOCK_BIT_POS  = 12;

  // gate status layout
  localparam int unsigned STAT_LOCK_VIOL_POS = 0;
  localparam int unsigned STAT_SETTLED_POS   = 1;
  localparam int unsigned STAT_ANY_GATED_POS = 2;

  localparam logic [DATA_W-1:0] GATE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] READ_ZERO  = 32'h00000000;

  // implemented gate bits per gate register
  localparam logic [DATA_W-1:0] GATE_MASK [NUM_GATE_REGS] = '{
    32'h00001101,  // converter, charge time unit, comparator reference
    32'h00000003,  // comparators a and b
    32'h001f001f,  // capture 1..5, compare 1..5
    32'h0000001f,  // timers 1..5
    32'h0103031f,  // serial 1..5, sync serial 1..2, two wire 1..2, usb
    32'h00010003   // calendar, reference clock out, parallel port
  };

  // flat peripheral index -> gate register and bit
  localparam int unsigned GATE_WORD [NUM_GATES] = '{
    0, 0, 0,
    1, 1,
    2, 2, 2, 2, 2, 2, 2, 2, 2, 2,
    3, 3, 3, 3, 3,
    4, 4, 4, 4, 4, 4, 4, 4, 4, 4,
    5, 5, 5
  };
  localparam int unsigned GATE_BIT [NUM_GATES] = '{
    0, 8, 12,
    0, 1,
    0, 1, 2, 3, 4, 16, 17, 18, 19, 20,
    0, 1, 2, 3, 4,
    0, 1, 2, 3, 4, 8, 9, 16, 17, 24,
    0, 1, 16
  };

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

endpackage

// file: verilog/periph_clock_enable.sv
`timescale 1ns/1ps
module periph_clock_enable
  import clock_gating_pkg::*;
#(
  parameter int unsigned N = NUM_GATES
) (
  input  wire logic         clk_sys_i,  // system clock
  input  wire logic         rst_n_i,    // async reset, active low
  input  wire logic [N-1:0] gate_i,     // one stops the peripheral
  output logic      [N-1:0] clk_en_o    // per peripheral clock enable
);

  // glitch free: peripherals use this as enable for every clock source
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_en
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          clk_en_o[g] <= 1'b1;
        end else begin
          clk_en_o[g] <= ~gate_i[g];
        end
      end
    end
  endgenerate

endmodule

// file: verilog/periph_csr_guard.sv
`timescale 1ns/1ps
module periph_csr_guard
  import clock_gating_pkg::*;
#(
  parameter int unsigned N = NUM_GATES
) (
  input  wire logic         clk_sys_i,   // system clock
  input  wire logic         rst_n_i,     // async reset, active low
  input  wire logic [N-1:0] gate_i,      // gate bits
  input  wire logic [N-1:0] csr_we_i,    // csr write strobes from bus decode
  input  wire logic [N-1:0] csr_rd_i,    // csr read strobes from bus decode
  output logic      [N-1:0] csr_we_o,    // write strobes passed to peripherals
  output logic      [N-1:0] rd_valid_o   // read data valid, one cycle after strobe
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_guard
      assign csr_we_o[g] = csr_we_i[g] & ~gate_i[g];
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          rd_valid_o[g] <= 1'b0;
        end else begin
          rd_valid_o[g] <= csr_rd_i[g] & ~gate_i[g];
        end
      end
    end
  endgenerate

endmodule

// file: verilog/peripheral_clock_gating.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
// Contract
// - a set gate bit stops all clocks of that peripheral
// - gated peripheral csr writes are dropped and reads flagged invalid
// - gate bits reset to zero; writing zero re-enables the peripheral while the gate lock bit is clear
// - gate one: converter bit 0, charge time bit 8, comparator reference bit 12
// - gate two: comparator a bit 0, comparator b bit 1
// - gate three: capture channels one to five at bits 0 to 4
// - gate three: compare channels one to five at bits 16 to 20
// - gate six: calendar bit 0, reference clock out bit 1, parallel port 16
module peripheral_clock_gating
  import clock_gating_pkg::*;
#(
  parameter int unsigned N = NUM_GATES
) (
  input  wire logic              clk_sys_i,      // system clock, 40 MHz
  input  wire logic              rst_n_i,        // async reset, active low
  input  wire logic              wb_cyc_i,       // wishbone cycle
  input  wire logic              wb_stb_i,       // wishbone strobe
  input  wire logic              wb_we_i,        // wishbone write
  input  wire logic [ADDR_W-1:0] wb_adr_i,       // wishbone byte address
  input  wire logic [SEL_W-1:0]  wb_sel_i,       // wishbone byte selects
  input  wire logic [DATA_W-1:0] wb_dat_i,       // wishbone write data
  output logic      [DATA_W-1:0] wb_dat_o,       // wishbone read data
  output logic                   wb_ack_o,       // wishbone acknowledge
  input  wire logic [N-1:0]      csr_we_i,       // peripheral csr write strobes
  input  wire logic [N-1:0]      csr_rd_i,       // peripheral csr read strobes
  output logic      [N-1:0]      csr_we_o,       // guarded csr write strobes
  output logic      [N-1:0]      csr_rd_valid_o, // csr read data valid
  output logic      [N-1:0]      clk_en_o,       // per peripheral clock enable
  output logic      [N-1:0]      gate_o,         // flat gate bits
  output logic      [DATA_W-1:0] sys_cfg_o       // system config control value
);

  wb_req_t           req;
  wb_rsp_t           rsp_reg;
  logic              ack_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] sys_cfg_reg;
  logic [DATA_W-1:0] gate_words_reg [NUM_GATE_REGS];
  logic [DATA_W-1:0] byte_mask;
  logic              access;
  logic              wr_commit;
  logic              hit_cfg;
  logic              hit_status;
  logic              hit_gate;
  logic [2:0]        gate_idx;
  logic              gate_lock;
  logic              lock_viol_reg;
  logic              lock_viol_set;
  logic              lock_viol_clr;
  logic              settled;
  logic              any_gated;
  logic [ADDR_W-1:0] gate_offset;

  assign req.cyc = wb_cyc_i;
  assign req.stb = wb_stb_i;
  assign req.we  = wb_we_i;
  assign req.adr = wb_adr_i;
  assign req.sel = wb_sel_i;
  assign req.dat = wb_dat_i;

  // bus handshake: ack one cycle after the request, dropped the cycle after
  assign access    = req.cyc & req.stb;
  assign wr_commit = access & req.we & ack_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end

  // address decode
  assign gate_offset = req.adr - GATE_REG_BASE;

  always_comb begin
    hit_cfg    = 1'b0;
    hit_status = 1'b0;
    hit_gate   = 1'b0;
    gate_idx   = 3'h0;
    if (req.adr[ADDR_W-1:2] == SYS_CFG_CTRL_ADDR[ADDR_W-1:2]) begin
      hit_cfg = 1'b1;
    end else if (req.adr[ADDR_W-1:2] == GATE_STATUS_ADDR[ADDR_W-1:2]) begin
      hit_status = 1'b1;
    end else if ((req.adr >= GATE_REG_BASE) &&
                 (gate_offset[ADDR_W-1:2] < NUM_GATE_REGS[ADDR_W-3:0])) begin
      hit_gate = 1'b1;
      gate_idx = gate_offset[4:2];
    end
  end

  // byte lane mask from selects
  genvar b;
  generate
    for (b = 0; b < SEL_W; b++) begin : g_lane
      assign byte_mask[b*8 +: 8] = {8{req.sel[b]}};
    end
  endgenerate

  // system config control register, lock bit included
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_cfg_reg <= SYS_CFG_RESET;
    end else if (wr_commit && hit_cfg) begin
      // read-only bits keep their reset value, only masked bits take the write
      sys_cfg_reg <= (sys_cfg_reg & ~SYS_CFG_WR_MASK) |
                     (((sys_cfg_reg & ~byte_mask) | (req.dat & byte_mask)) & SYS_CFG_WR_MASK);
    end
  end

  assign gate_lock = sys_cfg_reg[GATE_LOCK_BIT_POS];

  // gate registers; unimplemented bits hold zero
  genvar r;
  generate
    for (r = 0; r < NUM_GATE_REGS; r++) begin : g_gate_reg
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gate_words_reg[r] <= GATE_RESET;
        end else if (wr_commit && hit_gate && !gate_lock &&
                     (gate_idx == 3'(r))) begin
          // writing zero to a bit re-enables the peripheral
          gate_words_reg[r] <= ((gate_words_reg[r] & ~byte_mask) |
                                (req.dat & byte_mask)) & GATE_MASK[r];
        end
      end
    end
  endgenerate

  // flat gate vector: per peripheral placement within the gate registers
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_map
      assign gate_o[g] = gate_words_reg[GATE_WORD[g]][GATE_BIT[g]];
    end
  endgenerate

  // sticky flag: a gate write refused because of the lock; set wins over clear
  assign lock_viol_set = wr_commit & hit_gate & gate_lock;
  assign lock_viol_clr = wr_commit & hit_status & req.sel[0] & req.dat[STAT_LOCK_VIOL_POS];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_viol_reg <= 1'b0;
    end else if (lock_viol_set) begin
      lock_viol_reg <= 1'b1;
    end else if (lock_viol_clr) begin
      lock_viol_reg <= 1'b0;
    end
  end

  // clock enables agree with the gate bits once the enable stage caught up
  assign settled   = (clk_en_o == ~gate_o);
  assign any_gated = |gate_o;

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = READ_ZERO;
    if (hit_cfg) begin
      rdata_next = sys_cfg_reg;
    end else if (hit_status) begin
      rdata_next[STAT_LOCK_VIOL_POS] = lock_viol_reg;
      rdata_next[STAT_SETTLED_POS]   = settled;
      rdata_next[STAT_ANY_GATED_POS] = any_gated;
    end else if (hit_gate) begin
      rdata_next = gate_words_reg[gate_idx];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= READ_ZERO;
    end else if (access && !ack_reg && !req.we) begin
      rdata_reg <= rdata_next;
    end
  end

  assign rsp_reg.ack = ack_reg;
  assign rsp_reg.dat = rdata_reg;
  assign wb_ack_o    = rsp_reg.ack;
  assign wb_dat_o    = rsp_reg.dat;
  assign sys_cfg_o   = sys_cfg_reg;

  // software keeps the peripheral enable and usb busy order; no check here
  periph_clock_enable #(
    .N (N)
  ) u_clk_en (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .gate_i    (gate_o),
    .clk_en_o  (clk_en_o)
  );

  periph_csr_guard #(
    .N (N)
  ) u_guard (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .gate_i     (gate_o),
    .csr_we_i   (csr_we_i),
    .csr_rd_i   (csr_rd_i),
    .csr_we_o   (csr_we_o),
    .rd_valid_o (csr_rd_valid_o)
  );

endmodule

// file: tb/clock_gating_chk.sv
`timescale 1ns/1ps
module clock_gating_chk
  import clock_gating_pkg::*;
#(
  parameter int unsigned N = NUM_GATES
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0]  wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic [N-1:0]      csr_we_i,
  input wire logic [N-1:0]      csr_rd_i,
  input wire logic [N-1:0]      csr_we_o,
  input wire logic [N-1:0]      csr_rd_valid_o,
  input wire logic [N-1:0]      clk_en_o,
  input wire logic [N-1:0]      gate_o,
  input wire logic [DATA_W-1:0] sys_cfg_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  clk_follow_a: assert property (1'b1 |=> clk_en_o == ~$past(gate_o))
    else $error("clock enable not following gate");
  we_guard_a: assert property (csr_we_o == (csr_we_i & ~gate_o))
    else $error("write strobe passed to gated peripheral");
  rd_guard_a: assert property (1'b1 |=> csr_rd_valid_o == ($past(csr_rd_i) & ~$past(gate_o)))
    else $error("read valid wrong");
  lock_hold_a: assert property (sys_cfg_o[GATE_LOCK_BIT_POS] && wb_ack_o && wb_we_i |=> $stable(gate_o))
    else $error("gate changed while locked");
  gate_cause_a: assert property (!$stable(gate_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("gate changed without write");
  cfg_cause_a: assert property (!$stable(sys_cfg_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("config changed without write");
endmodule

bind peripheral_clock_gating clock_gating_chk #(.N(N)) chk_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .csr_we_i(csr_we_i), .csr_rd_i(csr_rd_i),
  .csr_we_o(csr_we_o), .csr_rd_valid_o(csr_rd_valid_o), .clk_en_o(clk_en_o),
  .gate_o(gate_o), .sys_cfg_o(sys_cfg_o));

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import clock_gating_pkg::*;
  logic        clk_sys_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [15:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0, rdat, dat_o, cfg_o;
  logic [31:0] sh [6];
  logic [32:0] cwe = '0, crd = '0, p, we_o, rv_o, ce_o, g_o;
  int          error_cnt = 0, checked = 0;
  int unsigned pos [33] = '{0, 8, 12, 32, 33, 64, 65, 66, 67, 68, 80, 81, 82, 83, 84,
    96, 97, 98, 99, 100, 128, 129, 130, 131, 132, 136, 137, 144, 145, 152, 160, 161, 176};
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cwe <= 33'({$urandom(), $urandom()});
    crd <= 33'({$urandom(), $urandom()});
  end
  peripheral_clock_gating peripheral_clock_gating_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .csr_we_i(cwe),
    .csr_rd_i(crd), .csr_we_o(we_o), .csr_rd_valid_o(rv_o), .clk_en_o(ce_o),
    .gate_o(g_o), .sys_cfg_o(cfg_o));
  task wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [32:0] e, input logic [32:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_sys_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  function automatic logic [32:0] flat();
    logic [32:0] f;
    for (int k = 0; k < 33; k++) f[k] = sh[pos[k] / 32][pos[k] % 32];
    return f;
  endfunction
  function automatic logic [31:0] mk(input int w);
    logic [31:0] m;
    m = '0;
    for (int k = 0; k < 33; k++) if (pos[k] / 32 == w) m[pos[k] % 32] = 1'b1;
    return m;
  endfunction
  task wr(input int w, input logic [3:0] s, input logic [31:0] d, input logic lk);
    logic [31:0] lm;
    lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    wb(1, GATE_REG_BASE + 16'(4 * w), s, d);
    if (!lk) sh[w] = ((sh[w] & ~lm) | (d & lm)) & mk(w);
    #1 chk("gate", flat(), g_o);
    chk("csr_we", cwe & ~flat(), we_o);
    p = crd;
    @(posedge clk_sys_i) #1 chk("clk_en", ~flat(), ce_o);
    chk("rd_valid", p & ~flat(), rv_o);
    wb(0, GATE_REG_BASE + 16'(4 * w), 4'hf, 32'h00000000);
    chk("readback", {1'b0, sh[w]}, {1'b0, rdat});
  endtask
  initial begin
    void'($urandom(87408));
    for (int i = 0; i < 6; i++) sh[i] = '0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1;
    wb(0, SYS_CFG_CTRL_ADDR, 4'hf, 32'h00000000);
    chk("cfg_reset", 33'h0000000b, {1'b0, rdat});
    chk("clk_reset", '1, ce_o);
    for (int w = 0; w < 6; w++) wr(w, 4'hf, 32'h00000000, 0);
    // strobed peripherals keep no enable or busy state, so gating them is in order
    for (int k = 0; k < 33; k++) begin
      wr(pos[k] / 32, 4'hf, 32'h00000001 << (pos[k] % 32), 0);
      wr(pos[k] / 32, 4'hf, 32'h00000000, 0);
    end
    repeat (40) wr($urandom_range(5), 4'($urandom()), $urandom(), 0);
    wb(1, SYS_CFG_CTRL_ADDR, 4'hf, 32'h00001000);
    #1 chk("sys_cfg", 33'h00001002, {1'b0, cfg_o});
    wr(4, 4'hf, ~sh[4], 1);
    wb(0, GATE_STATUS_ADDR, 4'hf, 32'h00000000);
    chk("status", {30'h0, |flat(), 2'b11}, {1'b0, rdat});
    wb(1, GATE_STATUS_ADDR, 4'h1, 32'h00000001);
    wb(0, GATE_STATUS_ADDR, 4'hf, 32'h00000000);
    chk("status_clr", {30'h0, |flat(), 2'b10}, {1'b0, rdat});
    wb(1, SYS_CFG_CTRL_ADDR, 4'hf, 32'h00000000);
    #1 chk("sys_cfg", 33'h00000002, {1'b0, cfg_o});
    wr(4, 4'hf, 32'hffffffff, 0);
    wb(0, 16'h0100, 4'hf, 32'h00000000);
    chk("unmapped", 33'h00000000, {1'b0, rdat});
    wrap_up;
  end
  initial begin
    #(25 * 20000);
    error_cnt++;
    wrap_up;
  end
endmodule
